/* File: core/scfd_pkg.sv */
// Package with word layout, reset patterns and divider codes
package scfd_pkg;
    localparam int          SCFD_WORD_BITS   = 32;
    localparam int          SCFD_CNT_W       = 6;
    localparam logic [5:0]  SCFD_LAST_BIT    = 6'h1F;
    localparam int          SCFD_NUM_OUT     = 5;
    localparam int          SCFD_SEL_W       = 3;
    // Address field and word codes
    localparam logic [1:0]  SCFD_ADDR_WORD0  = 2'h0;
    localparam logic [1:0]  SCFD_ADDR_WORD1  = 2'h1;
    // Field positions
    localparam int          SCFD_EN_LSB      = 22;
    localparam int          SCFD_OUT0_DIVIDER_SELECT_LSB    = 15;
    localparam int          SCFD_OUT1_DIVIDER_SELECT_LSB    = 18;
    // Power-up contents of the two words
    localparam logic [31:0] SCFD_WORD0_RESET = 32'h6FE401FC;
    localparam logic [31:0] SCFD_WORD1_RESET = 32'h5B4401FD;
    // Enable bits and per-output select reset values
    localparam logic [4:0]  SCFD_EN_RESET    = 5'h1F;
    localparam logic [2:0]  SCFD_SEL0_RESET  = 3'h0;
    localparam logic [2:0]  SCFD_SEL1_RESET  = 3'h1;
    localparam logic [2:0]  SCFD_SEL2_RESET  = 3'h2;
    localparam logic [2:0]  SCFD_SEL34_RESET = 3'h3;
    // Prescaler counter width: divide-by-16 needs four bits
    localparam int          SCFD_DIV_W       = 4;
    // Host serial clock half period, less one, in system clocks
    localparam logic [3:0]  SCFD_HALF_PER    = 4'h2;
    // Host controller states
    typedef enum logic [2:0] {
        SCFD_IDLE,
        SCFD_FALL,
        SCFD_SETUP,
        SCFD_HIGH,
        SCFD_END
    } scfd_host_state_t;
endpackage

/* File: core/scfd_if.sv */
// Three-wire serial configuration link between host and divider
`timescale 1ns/100ps
interface scfd_if;
    logic serial_load_enable_n; // Frame, active low
    logic serial_clock;         // Shift clock, data taken on rise
    logic serial_data;          // Data, MSB first
    modport host   (output serial_load_enable_n, serial_clock, serial_data);
    modport device (input  serial_load_enable_n, serial_clock, serial_data);
endinterface

/* File: core/scfd_divider.sv */
// One output divider: picks a tap of the shared prescaler count
`timescale 1ns/100ps
module scfd_divider
    import scfd_pkg::*;
(
    input  wire logic                  i_clock,
    input  wire logic                  i_resetn,
    input  wire logic                  i_enable,
    input  wire logic [SCFD_DIV_W-1:0] i_count,
    input  wire logic                  i_tick,
    input  wire logic [SCFD_SEL_W-1:0] i_select,
    input  wire logic                  i_drive,
    output logic                       o_clock,
    output logic                       o_drive_enable
);
    // Tap of the common counter; code 0 follows the tick itself
    function automatic logic tap(input logic [SCFD_DIV_W-1:0] cnt,
                                 input logic tick,
                                 input logic [SCFD_SEL_W-1:0] sel);
        case (sel)
            3'h0:    tap = tick;
            3'h1:    tap = cnt[0];
            3'h2:    tap = cnt[1];
            3'h3:    tap = cnt[2];
            default: tap = cnt[3];
        endcase
    endfunction

    // Registered output; all taps share one counter so they stay aligned
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_clock        <= 1'b0;
            o_drive_enable <= 1'b0;
        end
        else if (i_enable)
        begin
            o_clock        <= tap(i_count, i_tick, i_select);
            o_drive_enable <= i_drive;
        end
    end
endmodule

/* File: core/scfd_device.sv */
// Serial-configured five-output clock divider, device end
// Summary of operation
// - Words are 32 bits, MSB first
// - Low two bits pick target register
// - Falling load enable starts a word
// - Load enable high ignores clock and data
// - Data sampled on serial clock rise
// - Rising load enable commits the word
// - Each word accepted on its own
// - Power-down clears dividers, floats outputs
// - Reset clears all dividers asynchronously
// - Power-up ratios 1, 2, 4, 8, 8
// - Word 0 bits 22-26 enable outputs
// - Host fills word 0 reserved bits
// - Host fills word 1 reserved bits
// - Word 1 holds output 0 and 1 selects
// - Outputs 0, 1 run x1, /2, /4, /8, /16
// - All outputs stay phase aligned
// - Host need only write words 0, 1
`timescale 1ns/100ps
module scfd_device
    import scfd_pkg::*;
(
    input  wire logic                    i_clock,
    input  wire logic                    i_resetn,
    input  wire logic                    i_clock_enable,
    input  wire logic                    i_power_down_n,
    scfd_if.device                       link,
    output logic [SCFD_NUM_OUT-1:0]      o_clock_out,
    output logic [SCFD_NUM_OUT-1:0]      o_clock_out_oe,
    output logic [SCFD_WORD_BITS-1:0]    o_word0,
    output logic [SCFD_WORD_BITS-1:0]    o_word1,
    output logic                         o_word_strobe
);
    logic                      le_d;       // Load enable, last cycle
    logic                      sclk_d;     // Serial clock, last cycle
    logic [SCFD_WORD_BITS-1:0] shift;      // Receive shifter
    logic [SCFD_CNT_W-1:0]     bit_count;  // Bits taken this frame
    logic [SCFD_DIV_W-1:0]     prescale;   // Shared divider counter
    logic                      tick;       // Divide-by-1 waveform
    logic                      div_resetn; // Divider clear, active low
    logic [SCFD_NUM_OUT-1:0]   drive;      // Enables gated by power
    logic [SCFD_SEL_W-1:0]     sel [SCFD_NUM_OUT]; // Per-output codes
    logic                      le_fall;    // Frame start seen
    logic                      le_rise;    // Frame end seen
    logic                      sclk_rise;  // Bit strobe in a frame
    logic                      commit;     // Good frame ends now

    // How a frame is taken:
    //  - a falling load enable clears the bit counter
    //  - each serial clock rise inside the frame shifts one bit in,
    //    so the first bit sent ends up as bit 31
    //  - a rising load enable commits the word when exactly 32 rises
    //    were seen; bits 1..0 then pick the word
    // Frames with fewer or more rises leave every word untouched,
    // so a glitch on the link cannot half-load a divider setting.
    // The pins are taken as synchronous to i_clock, so each level
    // on the link must last at least one cycle to be seen; there is
    // no filter against pulses shorter than that.
    // Words 2 and 3 are accepted and pulse the strobe, but nothing
    // here uses them, so they are not stored.
    //
    // How the outputs are made:
    //  - tick toggles every cycle and is the divide-by-1 output
    //  - prescale steps once per tick period, so its bits give the
    //    divide-by-2, 4, 8 and 16 outputs
    //  - each output registers one tap, so all share one time base
    //    and stay aligned whatever their ratios
    // Power-down and reset both clear the whole divider chain
    // asynchronously. The stored words survive power-down, so the
    // outputs come back with the last setting once it is released;
    // only reset brings back the power-up words.
    // Outputs 2 to 4 are not configurable here and keep their
    // power-up ratios of 4, 8 and 8.
    // The clock enable freezes every register, dividers included,
    // so the outputs simply hold their level while it is low.

    // Divider select field of one output, held in word 1
    function automatic logic [SCFD_SEL_W-1:0] sel_field(
        input logic [SCFD_WORD_BITS-1:0] word,
        input int                        lsb);
        sel_field = word[lsb +: SCFD_SEL_W];
    endfunction

    assign le_fall   = le_d && !link.serial_load_enable_n;
    assign le_rise   = !le_d && link.serial_load_enable_n;
    // Clock edges only count inside a frame
    assign sclk_rise = !sclk_d && link.serial_clock
                       && !link.serial_load_enable_n;
    // A frame counts only with exactly 32 rises
    assign commit    = le_rise
                       && bit_count == SCFD_LAST_BIT + 6'h01;

    // Load enable history, for both frame edges
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
            le_d <= 1'b1; // Idle level, so no false start
        else if (i_clock_enable)
            le_d <= link.serial_load_enable_n;
    end

    // Serial clock history; pins taken as synchronous
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
            sclk_d <= 1'b0; // Idle level, so no false rise
        else if (i_clock_enable)
            sclk_d <= link.serial_clock;
    end

    // Receive shifter, MSB arrives first
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
            shift <= '0;
        else if (i_clock_enable && sclk_rise)
            shift <= {shift[SCFD_WORD_BITS-2:0],
                      link.serial_data};
    end

    // Bit counter: cleared by a frame start, saturates one past 32
    // so that a frame with extra bits is told apart from a good one
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
            bit_count <= '0;
        else if (i_clock_enable)
        begin
            if (le_fall)
                bit_count <= '0;
            else if (sclk_rise && bit_count <= SCFD_LAST_BIT + 6'h01)
                bit_count <= bit_count + 6'h01;
        end
    end

    // Commit on frame end; short or long frames are dropped
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_word0 <= SCFD_WORD0_RESET;
            o_word1 <= SCFD_WORD1_RESET;
        end
        else if (i_clock_enable && commit)
        begin
            // Only the addressed word changes
            case (shift[1:0])
                SCFD_ADDR_WORD0: o_word0 <= shift;
                SCFD_ADDR_WORD1: o_word1 <= shift;
                default: ; // Words 2, 3 unused here
            endcase
        end
    end

    // Commit pulse, also for the unused words
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
            o_word_strobe <= 1'b0;
        else if (i_clock_enable)
            o_word_strobe <= commit;
    end

    // Power-down also clears the dividers
    assign div_resetn = i_resetn && i_power_down_n;

    // Base waveform: toggles each cycle, the divide-by-1 output
    always_ff @(posedge i_clock or negedge div_resetn)
    begin
        if (!div_resetn)
            tick <= 1'b0;
        else if (i_clock_enable)
            tick <= !tick;
    end

    // Shared prescaler, one step per tick period, so bit n of the
    // count is the tick divided by 2 to the n+1; every output taps
    // this one count, which keeps them phase aligned
    always_ff @(posedge i_clock or negedge div_resetn)
    begin
        if (!div_resetn)
            prescale <= '0;
        else if (i_clock_enable && !tick)
            prescale <= prescale + 4'h1;
    end

    // Select codes: outputs 2-4 keep their power-up ratios
    assign sel[0] = sel_field(o_word1, SCFD_OUT0_DIVIDER_SELECT_LSB);
    assign sel[1] = sel_field(o_word1, SCFD_OUT1_DIVIDER_SELECT_LSB);
    assign sel[2] = SCFD_SEL2_RESET;
    assign sel[3] = SCFD_SEL34_RESET;
    assign sel[4] = SCFD_SEL34_RESET;
    // Float every output while powered down
    assign drive  = o_word0[SCFD_EN_LSB +: SCFD_NUM_OUT]
                    & {SCFD_NUM_OUT{i_power_down_n}};

    // One divider per output
    for (genvar g = 0; g < SCFD_NUM_OUT; g++)
    begin : g_out
        scfd_divider u_div
        (
            .i_clock        (i_clock),
            .i_resetn       (div_resetn),
            .i_enable       (i_clock_enable),
            .i_count        (prescale),
            .i_tick         (tick),
            .i_select       (sel[g]),
            .i_drive        (drive[g]),
            .o_clock        (o_clock_out[g]),
            .o_drive_enable (o_clock_out_oe[g])
        );
    end
endmodule

/* File: core/scfd_host.sv */
// Host controller: shifts 32-bit words out over the serial link
`timescale 1ns/100ps
module scfd_host
    import scfd_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_resetn,
    input  wire logic        i_clock_enable,
    input  wire logic [1:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_write,
    input  wire logic        i_read,
    output logic [31:0]      o_rdata,
    scfd_if.host             link
);
    // Register map: 0 data to send (write starts), 1 status
    localparam logic [1:0] HOST_REG_DATA   = 2'h0;
    localparam logic [1:0] HOST_REG_STATUS = 2'h1;

    scfd_host_state_t          state;
    logic [SCFD_WORD_BITS-1:0] tx;        // Outgoing word
    logic [SCFD_CNT_W-1:0]     left;      // Bits still to send
    logic [3:0]                timer;     // Half-period timer
    logic                      done;      // Sticky transfer done

    // Sequencer: frame, MSB-first bits, frame end
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state                     <= SCFD_IDLE;
            tx                        <= '0;
            left                      <= '0;
            timer                     <= '0;
            link.serial_load_enable_n <= 1'b1;
            link.serial_clock         <= 1'b0;
            link.serial_data          <= 1'b0;
        end
        else if (i_clock_enable)
        begin
            case (state)
                SCFD_IDLE:
                    // Writes while busy are ignored
                    if (i_write && i_addr == HOST_REG_DATA)
                    begin
                        tx    <= i_wdata;
                        left  <= SCFD_LAST_BIT + 6'h01;
                        timer <= SCFD_HALF_PER;
                        state <= SCFD_FALL;
                        link.serial_load_enable_n <= 1'b0;
                    end
                SCFD_FALL, SCFD_SETUP:
                    if (timer != 4'h0)
                        timer <= timer - 4'h1;
                    else if (state == SCFD_FALL || left != 6'h00)
                    begin
                        // Data set a half period before rise
                        link.serial_clock <= 1'b0;
                        link.serial_data  <= tx[SCFD_WORD_BITS-1];
                        tx    <= {tx[SCFD_WORD_BITS-2:0], 1'b0};
                        left  <= left - 6'h01;
                        timer <= SCFD_HALF_PER;
                        state <= SCFD_HIGH;
                    end
                    else
                    begin
                        link.serial_clock <= 1'b0;
                        timer <= SCFD_HALF_PER;
                        state <= SCFD_END;
                    end
                SCFD_HIGH:
                    if (timer != 4'h0)
                        timer <= timer - 4'h1;
                    else
                    begin
                        link.serial_clock <= 1'b1;
                        timer <= SCFD_HALF_PER;
                        state <= SCFD_SETUP;
                    end
                SCFD_END:
                    if (timer != 4'h0)
                        timer <= timer - 4'h1;
                    else
                    begin
                        link.serial_load_enable_n <= 1'b1;
                        state <= SCFD_IDLE;
                    end
                default: state <= SCFD_IDLE;
            endcase
        end
    end

    // Done flag: set wins over the clear by a status read
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
            done <= 1'b0;
        else if (i_clock_enable)
        begin
            if (state == SCFD_END && timer == 4'h0)
                done <= 1'b1;
            else if (i_read && i_addr == HOST_REG_STATUS)
                done <= 1'b0;
        end
    end

    // Read data one cycle after the strobe, else zero
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
            o_rdata <= '0;
        else if (i_clock_enable)
        begin
            o_rdata <= '0;
            if (i_read && i_addr == HOST_REG_STATUS)
                o_rdata <= {30'h0, done, state != SCFD_IDLE};
        end
    end
endmodule

/* File: test/scfd_link_sva.sv */
// Checker for the three-wire configuration link between both ends
`timescale 1ns/100ps
module scfd_link_sva
(
    input  wire logic i_clock,
    input  wire logic i_resetn,
    input  wire logic serial_load_enable_n,
    input  wire logic serial_clock,
    input  wire logic serial_data
);
    logic [5:0] bit_cnt; // Clock rises seen in this frame
    logic       clk_q;   // Serial clock one cycle ago

    // Count rises inside a frame; the count clears while idle
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            bit_cnt <= 6'h00;
            clk_q   <= 1'b0;
        end
        else
        begin
            clk_q <= serial_clock;
            if (serial_load_enable_n)
                bit_cnt <= 6'h00;
            else if (serial_clock && !clk_q)
                bit_cnt <= bit_cnt + 6'h01;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);

    a_idle_clk_low:
        assert property (serial_load_enable_n |-> !serial_clock)
        else $error("Serial clock high outside a frame");
    a_start_clk_low:
        assert property ($fell(serial_load_enable_n) |-> !serial_clock)
        else $error("Frame opened with serial clock high");
    a_end_clk_low:
        assert property ($rose(serial_load_enable_n) |-> !$past(serial_clock))
        else $error("Frame closed with serial clock high");
    a_first_rise_soon:
        assert property ($fell(serial_load_enable_n) |-> ##[1:8] serial_clock)
        else $error("No serial clock rise after frame start");
    a_clk_high_width:
        assert property ($rose(serial_clock) |-> serial_clock[*3] ##1 !serial_clock)
        else $error("Serial clock high time wrong");
    a_clk_low_width:
        assert property ($fell(serial_clock) |-> !serial_clock[*3])
        else $error("Serial clock low time wrong");
    a_data_at_rise:
        assert property ($rose(serial_clock) |-> $stable(serial_data))
        else $error("Data changed at serial clock rise");
    a_data_hold_high:
        assert property (serial_clock && $past(serial_clock) |-> $stable(serial_data))
        else $error("Data changed while serial clock high");
    a_bit_count:
        assert property ($rose(serial_load_enable_n) |-> bit_cnt == 6'h20)
        else $error("Frame did not carry 32 bits");
endmodule

/* File: test/testbench.sv */
// Self-checking bench: host and divider joined over the serial link
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    error_cnt++; $display("Error at %0t: got %h want %h", $time, g, e); end end
module testbench
    import scfd_pkg::*;
;
    logic        clock  = 1'b0;  // System clock
    logic        resetn = 1'b0;  // Async reset, low
    logic        pdn    = 1'b1;  // Power-down, low
    logic [1:0]  addr   = 2'h0;  // Host bus address
    logic [31:0] wdata  = 32'h0; // Host bus write data
    logic        wr     = 1'b0;  // Write strobe
    logic        rd     = 1'b0;  // Read strobe
    logic [31:0] rdata;          // Read data
    logic [4:0]  clk_out;        // Divided clocks
    logic [4:0]  oe;             // Drive enables
    logic [31:0] word0;          // Committed word 0
    logic [31:0] word1;          // Committed word 1
    logic        strobe;         // Commit pulse
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          strobes = 0;    // Pulses seen
    int          m_strobes = 0;  // Pulses expected
    logic [31:0] m_word [2];     // Model of stored words
    logic [31:0] seed = 32'h00015787;

    scfd_if link ();
    scfd_host u_scfd_host (.i_clock(clock), .i_resetn(resetn),
        .i_clock_enable(1'b1), .i_addr(addr), .i_wdata(wdata), .i_write(wr),
        .i_read(rd), .o_rdata(rdata), .link(link));
    scfd_device u_scfd_device (.i_clock(clock), .i_resetn(resetn),
        .i_clock_enable(1'b1), .i_power_down_n(pdn), .link(link),
        .o_clock_out(clk_out), .o_clock_out_oe(oe), .o_word0(word0),
        .o_word1(word1), .o_word_strobe(strobe));
    scfd_link_sva u_scfd_link_sva (.i_clock(clock), .i_resetn(resetn),
        .serial_load_enable_n(link.serial_load_enable_n),
        .serial_clock(link.serial_clock), .serial_data(link.serial_data));

    // Free-running clock, 100 ns period
    initial forever #50 clock = ~clock;

    // Cycle ceiling and commit pulse count
    always @(posedge clock)
    begin
        cycles++;
        if (strobe === 1'b1)
            strobes++;
        if (cycles == 20000)
        begin
            error_cnt++;
            stop_test();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Codes above 4 also give the slowest ratio
    function automatic int ratio(input logic [2:0] s);
        return (s > 3'h4) ? 16 : (1 << s);
    endfunction

    task automatic bus_write(input logic [1:0] a, input logic [31:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic bus_read(input logic [1:0] a, output logic [31:0] d);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // One frame; polling is bounded so a stuck host ends the wait
    task automatic send(input logic [31:0] w);
        logic [31:0] st;
        int          n;
        bus_write(2'h0, w);
        st = 32'h1;
        n = 0;
        while (st[0] !== 1'b0 && n < 200)
        begin
            bus_read(2'h1, st);
            n++;
        end
        `CHK(st, 32'h2)
        if (w[1:0] < 2'h2)
            m_word[w[0]] = w;
        m_strobes++;
        n = 0;
        while (strobes < m_strobes && n < 10)
        begin
            @(posedge clock);
            n++;
        end
        `CHK(strobes, m_strobes)
    endtask

    // Period of one output in cycles, from two rises
    task automatic measure(input int i, output int p);
        logic last;
        int   n;
        n = 0;
        p = 0;
        last = clk_out[i];
        for (int c = 0; c < 80 && n < 2; c++)
        begin
            @(posedge clock);
            #1;
            if (clk_out[i] === 1'b1 && last === 1'b0)
            begin
                n++;
                p = (n == 1) ? c : c - p;
            end
            last = clk_out[i];
        end
    endtask

    // Words, enables and every enabled ratio against the model
    task automatic check_outs();
        int r [5];
        int p;
        r = '{ratio(m_word[1][17:15]), ratio(m_word[1][20:18]), 4, 8, 8};
        `CHK(word0, m_word[0])
        `CHK(word1, m_word[1])
        `CHK(oe, m_word[0][26:22])
        for (int i = 0; i < 5; i++)
        begin
            if (m_word[0][22 + i])
            begin
                measure(i, p);
                `CHK(p, 2 * r[i])
            end
        end
    endtask

    task automatic stop_test();
        $display("Checks %0d, errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        logic [31:0] w0;
        logic [31:0] w1;
        logic [31:0] t;
        m_word[0] = SCFD_WORD0_RESET;
        m_word[1] = SCFD_WORD1_RESET;
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        #1 check_outs();
        // Select codes 0 to 5 on both outputs, random enables and order
        for (int k = 0; k < 6; k++)
        begin
            t = rnd();
            w0 = SCFD_WORD0_RESET;
            w0[26:22] = t[4:0];
            w1 = SCFD_WORD1_RESET;
            w1[20:15] = {3'(5 - k), 3'(k)};
            if (t[5])
            begin
                send(w0);
                send(w1);
            end
            else
            begin
                send(w1);
                send(w0);
            end
            check_outs();
        end
        // Spare address stores nothing; host ignores other registers
        t = rnd();
        send(t | 32'h3);
        bus_write(2'h3, 32'h0000_0001);
        bus_read(2'h1, t);
        `CHK(t, 32'h0)
        check_outs();
        // Power-down clears dividers and floats outputs
        @(posedge clock);
        pdn <= 1'b0;
        repeat (2) @(posedge clock);
        #1 `CHK(oe, 5'h00)
        `CHK(clk_out, 5'h00)
        @(posedge clock);
        pdn <= 1'b1;
        @(posedge clock);
        #1 check_outs();
        // Reset in mid-run brings back the power-up setup
        @(posedge clock);
        resetn <= 1'b0;
        #1 `CHK(clk_out, 5'h00)
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        m_word[0] = SCFD_WORD0_RESET;
        m_word[1] = SCFD_WORD1_RESET;
        @(posedge clock);
        #1 check_outs();
        stop_test();
    end
endmodule
